// >>> hw/readback_cfg.svh
// Constants for the configuration memory readback sequencer
`ifndef READBACK_CFG_SVH
`define READBACK_CFG_SVH
`define W_DUMMY        32'hFFFF_FFFF
`define W_BUS_SYNC     32'h0000_00BB
`define W_BUS_DETECT   32'h1122_0044
`define W_SYNC         32'hAA99_5566
`define W_NOOP         32'h2000_0000
`define W_HDR_CMD      32'h3000_8001
`define W_HDR_FRAME_AD 32'h3000_2001
`define W_HDR_FDO_RD0  32'h2800_6000
`define W_HDR_T2_READ  32'h4800_0000
`define T2_COUNT_MASK  32'h07FF_FFFF
`define CMD_SHUTDOWN   32'h0000_000B
`define CMD_RESET_CRC  32'h0000_0007
`define CMD_READ_CFG   32'h0000_0004
`define CMD_START      32'h0000_0005
`define CMD_REL_SYNC   32'h0000_000D
`define NOOPS_SETTLE   6'd5
`define NOOPS_FLUSH    6'd32
`define NOOPS_TAIL     6'd2
`define READ_LATENCY   2'd3
`define CLK_DIV_HALF   2'd2
`define SEQ_LEN        6'd38
`endif

// >>> hw/readback_pkg.sv
// Types for the configuration memory readback sequencer
package readback_pkg;
  typedef struct packed {
    logic [31:0] frame_addr;
    logic [15:0] words_per_frame;
    logic [15:0] frames;
  } job_t;

  typedef struct packed {
    logic [31:0] data;
    logic        first_frame;
  } word_out_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WRITE = 3'b001,
    ST_TURN  = 3'b010,
    ST_READ  = 3'b011,
    ST_BACK  = 3'b100,
    ST_TAIL  = 3'b101,
    ST_WAIT  = 3'b110
  } state_t;
endpackage

// >>> hw/level_sync.sv
// Two flip-flop synchroniser for a single level
`timescale 1ns/100ps
module level_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_level,
  output logic      o_level
);
  logic meta;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta    <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      meta    <= i_level;
      o_level <= meta;
    end
  end
endmodule // level_sync

// >>> hw/word_rom.sv
// Write-phase word table, indexed by step
`include "readback_cfg.svh"
`timescale 1ns/100ps
module word_rom (
  input  wire logic [5:0]  i_index,
  input  wire logic [31:0] i_frame_addr,
  input  wire logic [31:0] i_read_count,
  output logic      [31:0] o_word
);
  always_comb
  begin
    case (i_index)
      6'd0, 6'd3 : o_word = `W_DUMMY;
      6'd1       : o_word = `W_BUS_SYNC;
      6'd2       : o_word = `W_BUS_DETECT;
      6'd4       : o_word = `W_SYNC;
      6'd5       : o_word = `W_NOOP;
      6'd6       : o_word = `W_HDR_CMD;
      6'd7       : o_word = `CMD_SHUTDOWN;
      6'd8       : o_word = `W_NOOP;
      6'd9       : o_word = `W_HDR_CMD;
      6'd10      : o_word = `CMD_RESET_CRC;
      6'd11      : o_word = `W_NOOP;
      6'd17      : o_word = `W_HDR_CMD;
      6'd18      : o_word = `CMD_READ_CFG;
      6'd19      : o_word = `W_NOOP;
      6'd20      : o_word = `W_HDR_FRAME_AD;
      6'd21      : o_word = i_frame_addr;
      6'd22      : o_word = `W_HDR_FDO_RD0;
      6'd23      : o_word = `W_HDR_T2_READ | (i_read_count & `T2_COUNT_MASK);
      6'd24      : o_word = `W_NOOP;
      6'd25      : o_word = `W_HDR_CMD;
      6'd26      : o_word = `CMD_START;
      6'd27      : o_word = `W_NOOP;
      6'd28      : o_word = `W_HDR_CMD;
      6'd29      : o_word = `CMD_RESET_CRC;
      6'd30      : o_word = `W_NOOP;
      6'd31      : o_word = `W_HDR_CMD;
      6'd32      : o_word = `CMD_REL_SYNC;
      default    : o_word = `W_NOOP;
    endcase
  end
endmodule // word_rom

// >>> hw/readback_seq.sv
// Host sequencer that reads back configuration frame memory over the parallel port
`include "readback_cfg.svh"
`timescale 1ns/100ps
module readback_seq (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_start,
  input  readback_pkg::job_t         i_job,
  output logic                       o_busy,
  output logic                       o_finished,
  output readback_pkg::word_out_t    o_word,
  output logic                       o_word_valid,
  output logic                       o_config_clock,
  output logic                       o_chip_select_n,
  output logic                       o_read_write_select,
  output logic [31:0]                o_data_out,
  output logic                       o_data_oe,
  input  wire logic [31:0]           i_data_in,
  input  wire logic                  i_done
);
  readback_pkg::state_t state;
  readback_pkg::state_t next_state;
  logic [1:0]  div;
  logic [1:0]  next_div;
  logic        link_clk;
  logic        next_link_clk;
  logic [5:0]  index;
  logic [5:0]  next_index;
  logic [31:0] count;
  logic [31:0] next_count;
  logic [31:0] frame_left;
  logic [31:0] next_frame_left;
  logic [1:0]  lat;
  logic [1:0]  next_lat;
  logic        first;
  logic        next_first;
  logic        cs_n;
  logic        next_cs_n;
  logic        rdwr;
  logic        next_rdwr;
  logic        oe;
  logic        next_oe;
  logic [31:0] dout;
  logic [31:0] next_dout;
  readback_pkg::word_out_t wout;
  readback_pkg::word_out_t next_wout;
  logic        wval;
  logic        next_wval;
  logic        fin;
  logic        next_fin;
  readback_pkg::job_t job;
  readback_pkg::job_t next_job;
  logic [31:0] total;
  logic [31:0] rom_word;
  logic        done_s;
  logic [31:0] din_s;
  logic        fall;

  // Host makes the link clock by dividing its own clock; no second domain
  // Outputs move on the falling link edge so they stand still around each rising edge the device samples
  assign fall  = (div == `CLK_DIV_HALF - 2'd1) && link_clk;
  assign total = 32'(job.words_per_frame) * (32'(job.frames) + 32'd1);

  level_sync u_done_sync (
    .i_clk   (i_mclk),
    .i_rst_n (i_rst_n),
    .i_level (i_done),
    .o_level (done_s)
  );

  // Read data comes from pins: two flops per bit before the read logic takes it
  for (genvar b = 0; b < 32; b++)
  begin : g_din_sync
    level_sync u_din_sync (
      .i_clk   (i_mclk),
      .i_rst_n (i_rst_n),
      .i_level (i_data_in[b]),
      .o_level (din_s[b])
    );
  end

  word_rom u_rom (
    .i_index      (index),
    .i_frame_addr (job.frame_addr),
    .i_read_count (total),
    .o_word       (rom_word)
  );

  always_comb
  begin
    next_state      = state;
    next_div        = (div == `CLK_DIV_HALF - 2'd1) ? 2'd0 : div + 2'd1;
    next_link_clk   = (div == `CLK_DIV_HALF - 2'd1) ? !link_clk : link_clk;
    next_index      = index;
    next_count      = count;
    next_frame_left = frame_left;
    next_lat        = lat;
    next_first      = first;
    next_cs_n       = cs_n;
    next_rdwr       = rdwr;
    next_oe         = oe;
    next_dout       = dout;
    next_wout       = wout;
    next_wval       = 1'b0;
    next_fin        = 1'b0;
    next_job        = job;
    // Pin outputs change only on falling edges so the device samples stable values; o_word_valid and o_finished pulses clear on the next clock
    if (fall)
    begin
      case (state)
        readback_pkg::ST_IDLE:
        begin
          if (i_start)
          begin
            next_job   = i_job;
            next_index = 6'd0;
            next_state = readback_pkg::ST_WRITE;
          end
        end
        readback_pkg::ST_WRITE:
        begin
          // the table walks write words 0 to 24; words 25 to 32 go out in ST_WAIT
          next_cs_n  = 1'b0;
          next_rdwr  = 1'b0;
          next_oe    = 1'b1;
          next_dout  = rom_word;
          next_index = index + 6'd1;
          if (index == 6'd24)
          begin
            // Flush run: reuse count for thirty-two no-ops
            next_count = 32'(`NOOPS_FLUSH) - 32'd1;
            next_state = readback_pkg::ST_TAIL;
            next_index = 6'd24;
          end
        end
        readback_pkg::ST_TAIL:
        begin
          next_dout = `W_NOOP;
          if (count == 32'd0)
          begin
            next_cs_n  = 1'b1;
            next_state = readback_pkg::ST_TURN;
          end
          else
            next_count = count - 32'd1;
        end
        readback_pkg::ST_TURN:
        begin
          next_oe    = 1'b0;
          next_rdwr  = 1'b1;
          // Synchronised read data trails the pins by one more link cycle
          next_lat   = `READ_LATENCY;
          next_count = total;
          next_frame_left = 32'(job.words_per_frame);
          next_first = 1'b1;
          next_state = readback_pkg::ST_READ;
        end
        readback_pkg::ST_READ:
        begin
          next_cs_n = 1'b0;
          if (!cs_n && lat != 2'd0)
            next_lat = lat - 2'd1;
          else if (!cs_n && count != 32'd0)
          begin
            next_wout.data        = din_s;
            next_wout.first_frame = first;
            next_wval             = !first;
            next_count            = count - 32'd1;
            if (frame_left == 32'd1)
            begin
              next_first      = 1'b0;
              next_frame_left = 32'(job.words_per_frame);
            end
            else
              next_frame_left = frame_left - 32'd1;
            if (count == 32'd1)
            begin
              next_cs_n  = 1'b1;
              next_state = readback_pkg::ST_BACK;
            end
          end
        end
        readback_pkg::ST_BACK:
        begin
          next_rdwr  = 1'b0;
          next_oe    = 1'b1;
          next_dout  = `W_NOOP;
          next_index = 6'd24;
          next_state = readback_pkg::ST_WAIT;
        end
        readback_pkg::ST_WAIT:
        begin
          // trailer words then clock until done
          next_cs_n = 1'b0;
          next_dout = rom_word;
          // Index 32 is release-sync; the tail no-ops go out before done is looked at
          if (index < 6'd33 + `NOOPS_TAIL)
            next_index = index + 6'd1;
          else if (done_s)
          begin
            next_cs_n  = 1'b1;
            next_oe    = 1'b0;
            next_fin   = 1'b1;
            next_state = readback_pkg::ST_IDLE;
          end
        end
        default: next_state = readback_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state      <= readback_pkg::ST_IDLE;
      div        <= 2'd0;
      link_clk   <= 1'b0;
      index      <= 6'd0;
      count      <= 32'd0;
      frame_left <= 32'd0;
      lat        <= 2'd0;
      first      <= 1'b0;
      cs_n       <= 1'b1;
      rdwr       <= 1'b0;
      oe         <= 1'b0;
      dout       <= 32'h0000_0000;
      wout       <= '0;
      wval       <= 1'b0;
      fin        <= 1'b0;
      job        <= '0;
    end
    else
    begin
      state      <= next_state;
      div        <= next_div;
      link_clk   <= next_link_clk;
      index      <= next_index;
      count      <= next_count;
      frame_left <= next_frame_left;
      lat        <= next_lat;
      first      <= next_first;
      cs_n       <= next_cs_n;
      rdwr       <= next_rdwr;
      oe         <= next_oe;
      dout       <= next_dout;
      wout       <= next_wout;
      wval       <= next_wval;
      fin        <= next_fin;
      job        <= next_job;
    end
  end

  assign o_busy              = (state != readback_pkg::ST_IDLE);
  assign o_finished          = fin;
  assign o_word              = wout;
  assign o_word_valid        = wval;
  assign o_config_clock      = link_clk;
  assign o_chip_select_n     = cs_n;
  assign o_read_write_select = rdwr;
  assign o_data_out          = dout;
  assign o_data_oe           = oe;

  sequence s_dir_change;
    $changed(rdwr);
  endsequence

  chk_dir_needs_deselect: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_dir_change |-> cs_n) else $error("direction changed while selected");
  chk_read_no_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    rdwr |-> !oe) else $error("host drives data in read direction");
  chk_first_frame_dropped: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    wval |-> !wout.first_frame) else $error("dummy frame word passed on");
  chk_read_count_math: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state == readback_pkg::ST_TURN && fall) |=> count == total) else $error("bad read count");
  chk_latency_wait: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ($fell(cs_n) && rdwr) |-> !wval [*8]) else $error("data taken too early");
  chk_flush_noop: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state == readback_pkg::ST_TAIL && !cs_n) |-> dout == `W_NOOP || $past(state) != readback_pkg::ST_TAIL)
    else $error("flush word not a no-op");
  chk_finish_needs_done: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    fin |-> done_s) else $error("finished without done");
  chk_sync_word: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state == readback_pkg::ST_WRITE && index == 6'd4 && fall) |=> dout == `W_SYNC)
    else $error("sync word out of order");
endmodule // readback_seq

// >>> tb/cfg_device_model.sv
// Behavioural configuration device on the far side of the parallel port
`include "readback_cfg.svh"
`timescale 1ns/100ps
module cfg_device_model #(
  parameter int DONE_LAG = 4
) (
  input  wire logic        i_config_clock,
  input  wire logic        i_chip_select_n,
  input  wire logic        i_read_write_select,
  input  wire logic [31:0] i_data_out,
  input  wire logic        i_data_oe,
  input  wire logic [31:0] i_seed,
  output logic [31:0]      o_data_in,
  output logic             o_done
);
  logic [31:0] wr_q[$];
  logic [31:0] prev    = '0;
  logic [31:0] rd_word = '0;
  logic [31:0] last    = '0;
  logic        rd_on   = 1'b0;
  logic        done    = 1'b1;
  int          sel_cnt = 0;
  int          tail    = -1;
  logic [31:0] bus;

  // Released lines show a changing pattern, not the last value
  assign bus = i_data_oe ? i_data_out : (rd_on ? rd_word : ~last);
  assign o_data_in = bus;
  assign o_done = done;

  always @(posedge i_config_clock)
  begin
    last <= bus;
    if (!i_chip_select_n && !i_read_write_select)
    begin
      wr_q.push_back(bus);
      prev <= bus;
      if (prev == `W_HDR_CMD && bus == `CMD_SHUTDOWN)
        done <= 1'b0;
    end
    if (!i_chip_select_n && !i_read_write_select && prev == `W_HDR_CMD && bus == `CMD_REL_SYNC)
      tail <= 0;
    else if (tail >= 0)
    begin
      tail <= tail + 1;
      if (tail == 1 + DONE_LAG)
      begin
        done <= 1'b1;
        tail <= -1;
      end
    end
    // Stream starts with the dummy frame; first word stands after the third select clock
    if (!i_chip_select_n && i_read_write_select)
    begin
      sel_cnt <= sel_cnt + 1;
      rd_on <= (sel_cnt >= 2);
      rd_word <= i_seed + 32'(sel_cnt - 2);
    end
    else
    begin
      sel_cnt <= 0;
      rd_on <= 1'b0;
    end
  end
endmodule // cfg_device_model

// >>> tb/readback_seq_tb_top.sv
// Self-checking testbench for the readback sequencer
`include "readback_cfg.svh"
`timescale 1ns/100ps
module readback_seq_tb_top;
  logic                    i_mclk = 1'b0;
  logic                    i_rst_n = 1'b0;
  logic                    i_start = 1'b0;
  readback_pkg::job_t      i_job = '0;
  readback_pkg::word_out_t o_word;
  logic                    o_busy, o_finished, o_word_valid, o_config_clock;
  logic                    o_chip_select_n, o_read_write_select, o_data_oe, i_done;
  logic [31:0]             o_data_out, i_data_in;
  logic [31:0]             seed = '0;
  logic [31:0]             rnd = 32'h0000_003B;
  logic [31:0]             got_q[$];
  logic                    prev_rw = 1'b0;
  logic                    prev_cs = 1'b1;
  int                      n_mismatch = 0;
  int                      samples_checked = 0;
  int                      cycles = 0;
  int                      j;

  always #2 i_mclk = ~i_mclk;

  readback_seq i_readback_seq (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_start(i_start), .i_job(i_job),
    .o_busy(o_busy), .o_finished(o_finished), .o_word(o_word), .o_word_valid(o_word_valid),
    .o_config_clock(o_config_clock), .o_chip_select_n(o_chip_select_n),
    .o_read_write_select(o_read_write_select), .o_data_out(o_data_out), .o_data_oe(o_data_oe),
    .i_data_in(i_data_in), .i_done(i_done));

  cfg_device_model i_cfg_device_model (.i_config_clock(o_config_clock), .i_chip_select_n(o_chip_select_n),
    .i_read_write_select(o_read_write_select), .i_data_out(o_data_out), .i_data_oe(o_data_oe),
    .i_seed(seed), .o_data_in(i_data_in), .o_done(i_done));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge i_mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      n_mismatch++;
      test_done();
    end
    if (i_rst_n && o_read_write_select !== prev_rw)
      chk(32'(prev_cs & o_chip_select_n), 32'h0000_0001);
    if (o_read_write_select === 1'b1)
      chk(32'(o_data_oe), 32'h0000_0000);
    if (o_word_valid === 1'b1)
    begin
      got_q.push_back(o_word.data);
      chk(32'(o_word.first_frame), 32'h0000_0000);
    end
    prev_rw <= o_read_write_select;
    prev_cs <= o_chip_select_n;
  end

  task automatic run_job(input logic [15:0] wpf, input logic [15:0] frames, input logic [31:0] addr);
    logic [31:0] exp_q[$];
    logic [31:0] cnt;
    int          k;
    int          t;
    cnt = 32'(wpf) * (32'(frames) + 32'h0000_0001);
    exp_q = {`W_DUMMY, `W_BUS_SYNC, `W_BUS_DETECT, `W_DUMMY, `W_SYNC, `W_NOOP, `W_HDR_CMD, `CMD_SHUTDOWN,
      `W_NOOP, `W_HDR_CMD, `CMD_RESET_CRC, `W_NOOP};
    repeat (5) exp_q.push_back(`W_NOOP);
    exp_q = {exp_q, `W_HDR_CMD, `CMD_READ_CFG, `W_NOOP, `W_HDR_FRAME_AD, addr, `W_HDR_FDO_RD0,
      `W_HDR_T2_READ | (cnt & `T2_COUNT_MASK)};
    repeat (32) exp_q.push_back(`W_NOOP);
    exp_q = {exp_q, `W_NOOP, `W_HDR_CMD, `CMD_START, `W_NOOP, `W_HDR_CMD, `CMD_RESET_CRC, `W_NOOP,
      `W_HDR_CMD, `CMD_REL_SYNC};
    i_job <= '{frame_addr: addr, words_per_frame: wpf, frames: frames};
    i_start <= 1'b1;
    for (t = 0; t < 100 && o_busy !== 1'b1; t++)
      @(posedge i_mclk);
    chk(32'(o_busy), 32'h0000_0001);
    // A start held high while busy must not restart the sequence
    repeat (40) @(posedge i_mclk);
    i_start <= 1'b0;
    for (t = 0; t < 3000 && o_finished !== 1'b1; t++)
      @(posedge i_mclk);
    chk(32'(o_finished), 32'h0000_0001);
    chk(32'(o_busy), 32'h0000_0000);
    for (k = 0; k < exp_q.size(); k++)
      chk(i_cfg_device_model.wr_q[k], exp_q[k]);
    chk(32'(i_cfg_device_model.wr_q.size() >= exp_q.size() + 2), 32'h0000_0001);
    for (k = exp_q.size(); k < i_cfg_device_model.wr_q.size(); k++)
      chk(i_cfg_device_model.wr_q[k], `W_NOOP);
    chk(32'(got_q.size()), cnt - 32'(wpf));
    for (k = 0; k < got_q.size(); k++)
      chk(got_q[k], seed + 32'(wpf) + 32'(k));
    i_cfg_device_model.wr_q.delete();
    got_q.delete();
    repeat (8) @(posedge i_mclk);
  endtask

  initial
  begin
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    chk(32'(o_chip_select_n), 32'h0000_0001);
    for (j = 0; j < 3; j++)
    begin
      rnd = lfsr(rnd);
      seed <= rnd;
      rnd = lfsr(rnd);
      run_job(16'(rnd[2:0]) + 16'h0001, (j == 1) ? 16'h0000 : 16'(rnd[6:4]) + 16'h0001, rnd);
    end
    test_done();
  end
endmodule // readback_seq_tb_top
